// >>> pkg/tpo_pkg.sv
package tpo_pkg;
    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;

    // register indices, byte address is four times the index
    localparam logic [15:0] IDX_MODE = 16'hffa0;
    localparam logic [15:0] IDX_TRIG = 16'hffa1;
    localparam logic [15:0] IDX_ENH = 16'hffa2;
    localparam logic [15:0] IDX_ENL = 16'hffa3;
    localparam logic [15:0] IDX_NDH = 16'hffa4;
    localparam logic [15:0] IDX_NDL = 16'hffa5;
    localparam logic [15:0] IDX_NDH_ALT = 16'hffa6;
    localparam logic [15:0] IDX_NDL_ALT = 16'hffa7;
    localparam logic [15:0] IDX_FEED = 16'hffa8;
    localparam logic [15:0] IDX_DIRL = 16'hffd1;
    localparam logic [15:0] IDX_LATL = 16'hffd3;
    localparam logic [15:0] IDX_DIRH = 16'hffd4;
    localparam logic [15:0] IDX_LATH = 16'hffd6;

    // ----------------------------------------------------------------
    // reset values and fixed fields
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_RSV = 4'hf;
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [7:0] RST_TRIG = 8'hff;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic RST_PEND = 1'b1;
    localparam logic RST_FEED = 1'b0;
    localparam logic [3:0] NIB_ONES = 4'hf;
    localparam logic [7:0] BYTE_ONES = 8'hff;

    // feed control register fields
    localparam int FEED_EN_BIT = 0;
    localparam int FEED_EMPTY_BIT = 1;
    localparam int FEED_FULL_BIT = 2;
    localparam int FEED_PEND_BIT = 3;

    // pattern word buffer
    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 32;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
endpackage : tpo_pkg

// >>> src/timing_pattern_output.sv
`timescale 1ns/1ps

// --------------------------------------------------------------------
// pattern word buffer
// --------------------------------------------------------------------
module pattern_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH-1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic [AW:0] nxt_count;
    logic room_ff;
    logic avail_ff;
    logic push;
    logic pop;

    assign push = in_valid & room_ff;
    assign pop = avail_ff & out_ready;
    assign in_ready = room_ff;
    assign out_valid = avail_ff;
    assign out_data = mem[rd_ptr_ff];

    // storage, no reset needed on data
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // pointers wrap at depth, not at a power of two
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
            end
        end
    end

    // fill level
    always_comb begin
        nxt_count = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_count = count_ff - 1'b1;
        end
    end

    // flags registered so ready and valid leave straight from flops
    always_ff @(posedge mclk) begin
        if (reset) begin
            count_ff <= '0;
            room_ff <= 1'b1;
            avail_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            room_ff <= (nxt_count != FULL_CNT);
            avail_ff <= (nxt_count != '0);
        end
    end
endmodule : pattern_fifo

// --------------------------------------------------------------------
// pattern pulse unit
// --------------------------------------------------------------------
module timing_pattern_output (
    input wire logic mclk,
    input wire logic reset,
    input wire tpo_pkg::apb_req_t apb_req,
    output tpo_pkg::apb_rsp_t apb_rsp,
    input wire logic [3:0] cmp_match_a,
    input wire logic [3:0] cmp_match_b,
    input wire logic hw_standby,
    input wire logic dma_in_valid,
    input wire logic [15:0] dma_in_data,
    output logic dma_in_ready,
    output logic [3:0] dma_start,
    output logic [15:0] pattern_out_pins,
    output logic [15:0] pattern_oe
);
    logic [3:0] mode_ff;
    logic [7:0] trig_ff;
    logic [15:0] en_ff;
    logic [15:0] next_ff;
    logic [15:0] dir_ff;
    logic [15:0] latch_ff;
    logic feed_ff;
    logic pend_ff;
    logic [3:0] dma_start_ff;
    logic hws_meta_ff;
    logic hws_ff;
    tpo_pkg::apb_rsp_t rsp_ff;
    logic [15:0] grp_res;
    logic [3:0] grp_done;
    logic [15:0] nxt_latch;
    logic [15:0] nxt_next;
    logic setup;
    logic wr;
    logic aligned;
    logic [15:0] idx;
    logic [7:0] wdat;
    logic [7:0] rd_data;
    logic rd_hit;
    logic same_lo;
    logic same_hi;
    logic fifo_valid;
    logic [15:0] fifo_data;
    logic load;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign setup = apb_req.psel & ~apb_req.penable;
    assign aligned = (apb_req.paddr[1:0] == 2'h0);
    assign idx = apb_req.paddr[17:2];
    assign wr = apb_req.psel & apb_req.penable & rsp_ff.pready & apb_req.pwrite & aligned;
    assign wdat = apb_req.pwdata[7:0];
    assign same_lo = (trig_ff[1:0] == trig_ff[3:2]);
    assign same_hi = (trig_ff[5:4] == trig_ff[7:6]);

    // ----------------------------------------------------------------
    // per-group trigger and transfer
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 4; g++) begin : g_grp
        logic [1:0] sel;
        logic fa;
        logic fb;
        logic [3:0] l;
        logic [3:0] n;
        logic [3:0] e;
        logic [3:0] res;
        assign sel = trig_ff[2*g+1:2*g];
        assign fa = cmp_match_a[sel];
        assign fb = cmp_match_b[sel];
        assign l = latch_ff[4*g+:4];
        assign n = next_ff[4*g+:4];
        assign e = en_ff[4*g+:4];
        // non-overlap ends its cycle on b, so data reload waits for it
        assign grp_done[g] = mode_ff[g] ? fb : fa;
        // transfer, both edges on a in normal mode; in non-overlap falling on a, rising on b
        always_comb begin
            res = l;
            if (!mode_ff[g]) begin
                if (fa) begin
                    res = (l & ~e) | (n & e);
                end
            end else begin
                if (fa) begin
                    res = res & ~(e & ~n);
                end
                if (fb) begin
                    res = res | (e & n);
                end
            end
        end
        assign grp_res[4*g+:4] = res;
    end

    // ----------------------------------------------------------------
    // register read path
    // ----------------------------------------------------------------
    // split addresses fill unused nibbles with ones
    always_comb begin
        rd_data = 8'h00;
        rd_hit = aligned;
        case (idx)
            tpo_pkg::IDX_MODE: rd_data = {tpo_pkg::MODE_RSV, mode_ff};
            tpo_pkg::IDX_TRIG: rd_data = trig_ff;
            tpo_pkg::IDX_ENH: rd_data = en_ff[15:8];
            tpo_pkg::IDX_ENL: rd_data = en_ff[7:0];
            tpo_pkg::IDX_NDH: rd_data = same_hi ? next_ff[15:8] : {next_ff[15:12], tpo_pkg::NIB_ONES};
            tpo_pkg::IDX_NDL: rd_data = same_lo ? next_ff[7:0] : {next_ff[7:4], tpo_pkg::NIB_ONES};
            tpo_pkg::IDX_NDH_ALT: rd_data = same_hi ? tpo_pkg::BYTE_ONES : {tpo_pkg::NIB_ONES, next_ff[11:8]};
            tpo_pkg::IDX_NDL_ALT: rd_data = same_lo ? tpo_pkg::BYTE_ONES : {tpo_pkg::NIB_ONES, next_ff[3:0]};
            tpo_pkg::IDX_FEED: rd_data = {4'h0, pend_ff, ~dma_in_ready, ~fifo_valid, feed_ff};
            tpo_pkg::IDX_DIRL: rd_data = 8'h00;
            tpo_pkg::IDX_DIRH: rd_data = 8'h00;
            tpo_pkg::IDX_LATL: rd_data = latch_ff[7:0];
            tpo_pkg::IDX_LATH: rd_data = latch_ff[15:8];
            default: rd_hit = 1'b0;
        endcase
    end

    // answer in the access cycle right after setup, zero wait states
    always_ff @(posedge mclk) begin
        if (reset) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.pready <= setup;
            rsp_ff.pslverr <= setup & ~rd_hit;
            if (setup) begin
                rsp_ff.prdata <= {24'h000000, rd_hit ? rd_data : 8'h00};
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // mode f0 and trigger ff after reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_ff <= tpo_pkg::RST_MODE;
            trig_ff <= tpo_pkg::RST_TRIG;
            en_ff <= tpo_pkg::RST_ZERO;
            dir_ff <= tpo_pkg::RST_ZERO;
            feed_ff <= tpo_pkg::RST_FEED;
        end else if (wr) begin
            case (idx)
                tpo_pkg::IDX_MODE: mode_ff <= wdat[3:0];
                tpo_pkg::IDX_TRIG: trig_ff <= wdat;
                tpo_pkg::IDX_ENH: en_ff[15:8] <= wdat;
                tpo_pkg::IDX_ENL: en_ff[7:0] <= wdat;
                tpo_pkg::IDX_DIRL: dir_ff[7:0] <= wdat;
                tpo_pkg::IDX_DIRH: dir_ff[15:8] <= wdat;
                tpo_pkg::IDX_FEED: feed_ff <= wdat[tpo_pkg::FEED_EN_BIT];
                default: feed_ff <= feed_ff;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // next data and buffer feed
    // ----------------------------------------------------------------
    // hold off a load in a transfer cycle so a fresh word is never marked used
    assign load = feed_ff & fifo_valid & pend_ff & ~(|grp_done);

    // nibble write steering by trigger sameness
    always_comb begin
        nxt_next = next_ff;
        if (wr && idx == tpo_pkg::IDX_NDH) begin
            nxt_next[15:12] = wdat[7:4];
            if (same_hi) begin
                nxt_next[11:8] = wdat[3:0];
            end
        end
        if (wr && idx == tpo_pkg::IDX_NDH_ALT && !same_hi) begin
            nxt_next[11:8] = wdat[3:0];
        end
        if (wr && idx == tpo_pkg::IDX_NDL) begin
            nxt_next[7:4] = wdat[7:4];
            if (same_lo) begin
                nxt_next[3:0] = wdat[3:0];
            end
        end
        if (wr && idx == tpo_pkg::IDX_NDL_ALT && !same_lo) begin
            nxt_next[3:0] = wdat[3:0];
        end
    end

    // cleared by reset and hardware standby, buffer word beats cpu
    always_ff @(posedge mclk) begin
        if (reset || hws_ff) begin
            next_ff <= tpo_pkg::RST_ZERO;
        end else if (load) begin
            next_ff <= fifo_data;
        end else begin
            next_ff <= nxt_next;
        end
    end

    // used-data flag, a transfer sets it, a load clears it
    always_ff @(posedge mclk) begin
        if (reset) begin
            pend_ff <= tpo_pkg::RST_PEND;
        end else if (|grp_done) begin
            pend_ff <= 1'b1;
        end else if (load) begin
            pend_ff <= 1'b0;
        end
    end

    // one-cycle dma start per group transfer
    always_ff @(posedge mclk) begin
        if (reset) begin
            dma_start_ff <= 4'h0;
        end else begin
            dma_start_ff <= grp_done;
        end
    end

    // standby pin from outside the clock domain
    always_ff @(posedge mclk) begin
        if (reset) begin
            hws_meta_ff <= 1'b0;
            hws_ff <= 1'b0;
        end else begin
            hws_meta_ff <= hw_standby;
            hws_ff <= hws_meta_ff;
        end
    end

    pattern_fifo #(
        .WIDTH(tpo_pkg::FIFO_WIDTH),
        .DEPTH(tpo_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .in_valid(dma_in_valid),
        .in_ready(dma_in_ready),
        .in_data(dma_in_data),
        .out_valid(fifo_valid),
        .out_ready(load),
        .out_data(fifo_data)
    );

    // ----------------------------------------------------------------
    // port output latch
    // ----------------------------------------------------------------
    // cpu only reaches bits not in pattern use
    always_comb begin
        nxt_latch = grp_res;
        if (wr && idx == tpo_pkg::IDX_LATL) begin
            nxt_latch[7:0] = (grp_res[7:0] & en_ff[7:0]) | (wdat & ~en_ff[7:0]);
        end
        if (wr && idx == tpo_pkg::IDX_LATH) begin
            nxt_latch[15:8] = (grp_res[15:8] & en_ff[15:8]) | (wdat & ~en_ff[15:8]);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            latch_ff <= tpo_pkg::RST_ZERO;
        end else begin
            latch_ff <= nxt_latch;
        end
    end

    // pins show the latch; direction gates the pad driver
    assign pattern_out_pins = latch_ff;
    assign pattern_oe = dir_ff;
    assign dma_start = dma_start_ff;
    assign apb_rsp = rsp_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_bit_enable;
        !(wr && (idx == tpo_pkg::IDX_LATL || idx == tpo_pkg::IDX_LATH))
            |=> ((latch_ff ^ $past(latch_ff)) & ~$past(en_ff)) == 16'h0000;
    endproperty
    a_bit_enable: assert property (p_bit_enable) else $error("disabled bit moved");

    property p_trig_sel;
        !mode_ff[0] && cmp_match_a[trig_ff[1:0]] && en_ff[3:0] == 4'hf |=> latch_ff[3:0] == $past(next_ff[3:0]);
    endproperty
    a_trig_sel: assert property (p_trig_sel) else $error("selected trigger ignored");

    // transfer merges next data under enables
    property p_transfer;
        grp_done[1] && !mode_ff[1]
            |=> latch_ff[7:4] == (($past(next_ff[7:4]) & $past(en_ff[7:4])) | ($past(latch_ff[7:4]) & ~$past(en_ff[7:4])));
    endproperty
    a_transfer: assert property (p_transfer) else $error("group 1 transfer wrong");

    // compare a alone never raises a bit in non-overlap
    property p_non_overlap;
        mode_ff[2] && !cmp_match_b[trig_ff[5:4]] && !(wr && idx == tpo_pkg::IDX_LATH)
            |=> (latch_ff[11:8] & ~$past(latch_ff[11:8])) == 4'h0;
    endproperty
    a_non_overlap: assert property (p_non_overlap) else $error("rising edge before b");

    // dma start follows transfer one cycle later
    property p_dma_start;
        grp_done[3] |=> dma_start[3] ##1 !dma_start[3] || $past(grp_done[3]);
    endproperty
    a_dma_start: assert property (p_dma_start) else $error("dma start missing");

    // write to fully enabled latch ignored
    property p_latch_ro;
        wr && idx == tpo_pkg::IDX_LATL && en_ff[7:0] == 8'hff && grp_done[1:0] == 2'h0
            && (mode_ff[1:0] == 2'h0 || cmp_match_a == 4'h0) |=> $stable(latch_ff[7:0]);
    endproperty
    a_latch_ro: assert property (p_latch_ro) else $error("read-only bit written");

    // shared trigger leaves second low address all ones
    property p_low_split;
        setup && aligned && idx == tpo_pkg::IDX_NDL_ALT && same_lo |=> apb_rsp.prdata[7:0] == 8'hff;
    endproperty
    a_low_split: assert property (p_low_split) else $error("low alias wrong");

    // split trigger puts group 2 at second high address
    property p_high_split;
        setup && aligned && idx == tpo_pkg::IDX_NDH_ALT && !same_hi
            |=> apb_rsp.prdata[7:0] == {4'hf, $past(next_ff[11:8])};
    endproperty
    a_high_split: assert property (p_high_split) else $error("high alias wrong");

    property p_rsv_ones;
        setup && aligned && idx == tpo_pkg::IDX_NDL && !same_lo |=> apb_rsp.prdata[3:0] == 4'hf;
    endproperty
    a_rsv_ones: assert property (p_rsv_ones) else $error("reserved nibble not ones");

    property p_reset_vals;
        $past(reset) |-> mode_ff == 4'h0 && trig_ff == 8'hff && en_ff == 16'h0000 && latch_ff == 16'h0000;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

    property p_standby;
        hws_ff |=> next_ff == 16'h0000;
    endproperty
    a_standby: assert property (p_standby) else $error("standby kept next data");

    c_nonoverlap: cover property (mode_ff[0] && cmp_match_a[trig_ff[1:0]] ##[1:20] cmp_match_b[trig_ff[1:0]]);
    c_fifo_load: cover property (load ##[1:50] grp_done[0]);
    c_fifo_full: cover property (!dma_in_ready && dma_in_valid);
    c_split_write: cover property (wr && idx == tpo_pkg::IDX_NDL_ALT && !same_lo);
endmodule : timing_pattern_output

// >>> test/timer_partner.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// timer compare-match source
// ----------------------------------------------------------------
module timer_partner (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [3:0] req_a,
    input wire logic [3:0] req_b,
    output logic [3:0] cmp_match_a,
    output logic [3:0] cmp_match_b
);
    // registered so every match is a clean copy of its request, one cycle later on the edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            cmp_match_a <= 4'h0;
            cmp_match_b <= 4'h0;
        end else begin
            cmp_match_a <= req_a;
            cmp_match_b <= req_b;
        end
    end
endmodule : timer_partner

// >>> test/timing_pattern_output_tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// pattern unit bench
// ----------------------------------------------------------------
module timing_pattern_output_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    tpo_pkg::apb_req_t apb_req = '0;
    tpo_pkg::apb_rsp_t apb_rsp;
    logic [3:0] req_a = 4'h0;
    logic [3:0] req_b = 4'h0;
    logic [3:0] cmp_match_a;
    logic [3:0] cmp_match_b;
    logic hw_standby = 1'b0;
    logic dma_in_valid = 1'b0;
    logic [15:0] dma_in_data = 16'h0000;
    logic dma_in_ready;
    logic [3:0] dma_start;
    logic [15:0] pattern_out_pins;
    logic [15:0] pattern_oe;
    int err_count = 0;
    int samples_checked = 0;
    int starts [4] = '{default: 0};
    logic [31:0] seed = 32'hf772;
    logic [7:0] q;
    logic e;
    logic [15:0] pat = 16'h0000;
    logic [15:0] nd;
    logic [15:0] fq [$];
    logic [15:0] ridx [9] = '{tpo_pkg::IDX_MODE, tpo_pkg::IDX_TRIG, tpo_pkg::IDX_ENH, tpo_pkg::IDX_ENL,
        tpo_pkg::IDX_NDH, tpo_pkg::IDX_NDL, tpo_pkg::IDX_LATL, tpo_pkg::IDX_LATH, tpo_pkg::IDX_DIRL};
    logic [7:0] rexp [9] = '{8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    always #12.5 mclk = ~mclk;

    timing_pattern_output timing_pattern_output_inst (.mclk(mclk), .reset(reset), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .cmp_match_a(cmp_match_a), .cmp_match_b(cmp_match_b), .hw_standby(hw_standby),
        .dma_in_valid(dma_in_valid), .dma_in_data(dma_in_data), .dma_in_ready(dma_in_ready),
        .dma_start(dma_start), .pattern_out_pins(pattern_out_pins), .pattern_oe(pattern_oe));
    timer_partner timer_partner_inst (.mclk(mclk), .reset(reset), .req_a(req_a), .req_b(req_b),
        .cmp_match_a(cmp_match_a), .cmp_match_b(cmp_match_b));

    // count dma start pulses per group
    always @(posedge mclk) begin
        for (int g = 0; g < 4; g++) begin
            if (dma_start[g] === 1'b1) starts[g] <= starts[g] + 1;
        end
    end

    // ----------------------------------------------------------------
    // helpers and expectations
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // non-overlap: falls on a, rises on b, every bit taken as enabled
    function automatic logic [15:0] nov(input logic [15:0] lat, input logic [15:0] n, input logic on_b);
        return on_b ? (lat | n) : (lat & n);
    endfunction : nov

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // apb master: answer taken at the rising edge that sees pready, released right there
    task automatic apb(input logic [15:0] idx, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        apb_req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h000000, d}};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        q = apb_rsp.prdata[7:0];
        e = apb_rsp.pslverr;
        apb_req <= '0;
        // the write lands at that edge, so let it settle before callers look
        @(negedge mclk);
    endtask : apb

    task automatic fire(input logic [3:0] a, input logic [3:0] b);
        @(posedge mclk);
        req_a <= a;
        req_b <= b;
        @(posedge mclk);
        req_a <= 4'h0;
        req_b <= 4'h0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask : fire

    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done

    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out

    // watchdog, a few hundred cycles of work expected
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        close_out;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            apb(ridx[i], 1'b0, 8'h00);
            chk("reset register", {8'h00, rexp[i]}, {8'h00, q});
        end
        chk("reset pins", 16'h0000, pattern_out_pins);
        apb(16'hffb0, 1'b0, 8'h00);
        chk("unmapped error", 16'h0001, {15'h0000, e});
        done("reset");
        apb(tpo_pkg::IDX_DIRL, 1'b1, 8'hff);
        apb(tpo_pkg::IDX_DIRH, 1'b1, 8'hff);
        chk("pin enables", 16'hffff, pattern_oe);
        apb(tpo_pkg::IDX_ENL, 1'b1, 8'hff);
        apb(tpo_pkg::IDX_ENH, 1'b1, 8'hff);
        apb(tpo_pkg::IDX_TRIG, 1'b1, 8'h00);
        apb(tpo_pkg::IDX_MODE, 1'b1, 8'h00);
        apb(tpo_pkg::IDX_NDL_ALT, 1'b0, 8'h00);
        chk("shared alt reads ones", 16'h00ff, {8'h00, q});
        // shared trigger, corners first then random words
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            nd = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : seed[15:0];
            apb(tpo_pkg::IDX_NDL, 1'b1, nd[7:0]);
            apb(tpo_pkg::IDX_NDH, 1'b1, nd[15:8]);
            fire(4'h1, 4'h0);
            pat = nd;
            chk("shared transfer", pat, pattern_out_pins);
        end
        for (int g = 0; g < 4; g++) chk("dma starts", 16'h0004, starts[g][15:0]);
        done("shared");
        // writes to pattern bits are dropped, others land
        apb(tpo_pkg::IDX_LATL, 1'b1, ~pat[7:0]);
        apb(tpo_pkg::IDX_LATL, 1'b0, 8'h00);
        chk("latch guarded", {8'h00, pat[7:0]}, {8'h00, q});
        apb(tpo_pkg::IDX_ENL, 1'b1, 8'h0f);
        apb(tpo_pkg::IDX_LATL, 1'b1, 8'ha5);
        pat[7:4] = 4'ha;
        @(negedge mclk);
        chk("per bit enable", pat, pattern_out_pins);
        apb(tpo_pkg::IDX_ENL, 1'b1, 8'hff);
        done("latch");
        // split triggers: g0 ch0, g1 ch1, g2 ch2, g3 ch3
        apb(tpo_pkg::IDX_TRIG, 1'b1, 8'he4);
        apb(tpo_pkg::IDX_NDL, 1'b1, 8'h5a);
        apb(tpo_pkg::IDX_NDL, 1'b0, 8'h00);
        chk("split low", 16'h005f, {8'h00, q});
        apb(tpo_pkg::IDX_NDL_ALT, 1'b1, 8'h3c);
        apb(tpo_pkg::IDX_NDL_ALT, 1'b0, 8'h00);
        chk("split low alt", 16'h00fc, {8'h00, q});
        apb(tpo_pkg::IDX_NDH, 1'b1, 8'h96);
        apb(tpo_pkg::IDX_NDH, 1'b0, 8'h00);
        chk("split high", 16'h009f, {8'h00, q});
        apb(tpo_pkg::IDX_NDH_ALT, 1'b1, 8'h21);
        apb(tpo_pkg::IDX_NDH_ALT, 1'b0, 8'h00);
        chk("split high alt", 16'h00f1, {8'h00, q});
        nd = 16'h915c;
        for (int g = 0; g < 4; g++) begin
            fire(4'h1 << g, 4'h0);
            pat[g*4 +: 4] = nd[g*4 +: 4];
            chk("group transfer", pat, pattern_out_pins);
        end
        done("split");
        // non-overlap, a clears then b sets
        apb(tpo_pkg::IDX_TRIG, 1'b1, 8'h00);
        apb(tpo_pkg::IDX_MODE, 1'b1, 8'h0f);
        seed = xs(seed);
        nd = seed[15:0];
        apb(tpo_pkg::IDX_NDL, 1'b1, nd[7:0]);
        apb(tpo_pkg::IDX_NDH, 1'b1, nd[15:8]);
        fire(4'h1, 4'h0);
        pat = nov(pat, nd, 1'b0);
        chk("nonoverlap fall", pat, pattern_out_pins);
        fire(4'h0, 4'h1);
        pat = nov(pat, nd, 1'b1);
        chk("nonoverlap rise", pat, pattern_out_pins);
        // a and b in one cycle give a full transfer
        seed = xs(seed);
        nd = seed[15:0];
        apb(tpo_pkg::IDX_NDL, 1'b1, nd[7:0]);
        apb(tpo_pkg::IDX_NDH, 1'b1, nd[15:8]);
        fire(4'h1, 4'h1);
        pat = nov(nov(pat, nd, 1'b0), nd, 1'b1);
        chk("nonoverlap both", pat, pattern_out_pins);
        apb(tpo_pkg::IDX_MODE, 1'b1, 8'h00);
        done("nonoverlap");
        // hardware standby clears next data
        apb(tpo_pkg::IDX_NDL, 1'b1, 8'h3c);
        @(posedge mclk);
        hw_standby <= 1'b1;
        repeat (4) @(posedge mclk);
        hw_standby <= 1'b0;
        repeat (3) @(posedge mclk);
        apb(tpo_pkg::IDX_NDL, 1'b0, 8'h00);
        chk("standby clear", 16'h0000, {8'h00, q});
        done("standby");
        // buffer: fill until refused, then drain through triggers
        apb(tpo_pkg::IDX_FEED, 1'b1, 8'h01);
        @(posedge mclk);
        seed = xs(seed);
        dma_in_valid <= 1'b1;
        dma_in_data <= seed[15:0];
        for (int i = 0; i < 60; i++) begin
            @(negedge mclk);
            if (dma_in_ready !== 1'b1) break;
            fq.push_back(dma_in_data);
            @(posedge mclk);
            seed = xs(seed);
            dma_in_data <= seed[15:0];
        end
        @(posedge mclk);
        dma_in_valid <= 1'b0;
        apb(tpo_pkg::IDX_FEED, 1'b0, 8'h00);
        chk("buffer full", 16'h0001, {15'h0000, q[tpo_pkg::FEED_FULL_BIT]});
        foreach (fq[i]) begin
            fire(4'h1, 4'h0);
            chk("buffered word", fq[i], pattern_out_pins);
        end
        apb(tpo_pkg::IDX_FEED, 1'b0, 8'h00);
        chk("buffer empty", 16'h0001, {15'h0000, q[tpo_pkg::FEED_EMPTY_BIT]});
        done("buffer");
        close_out;
    end
endmodule : timing_pattern_output_tb
